//--- logic/viu_top.sv
// Vectored priority interrupt unit: request flags, enables, arbitration,
// and the stacking and vector fetch sequence for the processor core.
// Assumes an APB master, a core that signals instruction boundaries and
// a memory port whose read data arrives the cycle after the read strobe.
// How it works
// [R1] Fourteen sources: six pins, seven internal, break
// [R2] Maskable raised when request, enable set, unmasked
// [R3] Software sets and clears every enable bit
// [R4] Software clears request bits, never sets them
// [R5] Break ignores disable flag and enables
// [R6] Simultaneous requests served lowest priority number first
// [R7] Acceptance pushes program counter, then status
// [R8] Acceptance sets disable flag, clears served request
// [R9] Vector low byte even, high byte odd
// [R10] Software disables, changes edge, clears, re-enables
// [R11] Pin sources a-d: priorities 2,4,5,6
// [R12] Timer edge pins: priorities 14 and 15
// [R13] Timer x,y,2 underflows: priorities 8,9,11
// [R14] Timer 1 underflow priority 10, ends stop
// [R15] Serial receive priority 12, only when selected
// [R16] Serial transmit on shift done or empty
// [R17] Converter done: priority 16
// [R18] Break: unmaskable, lowest priority 17
// [R19] Reset fetches start vector, highest priority
// [R20] Each timer underflow sets its request bit
// [R21] Reserved priorities 3 and 7 never win
// [R22] Pins synchronised, compared with previous sample
//
// Local design decisions: the register offsets and the APB slave port.
module viu_top
  import viu_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Event sources
  input wire logic extIrqPinA,
  input wire logic extIrqPinB,
  input wire logic extIrqPinC,
  input wire logic extIrqPinD,
  input wire logic timerXEdgePin,
  input wire logic timerYEdgePin,
  input wire logic timerXUnderflow,
  input wire logic timerYUnderflow,
  input wire logic timer1Underflow,
  input wire logic timer2Underflow,
  input wire logic serialRxDone,
  input wire logic serialTxShiftDone,
  input wire logic serialTxBufEmpty,
  input wire logic adcDone,
  input wire logic breakInstruction,
  input wire logic stopModeInstruction,
  // Core side
  input wire logic instrBoundary,
  input wire logic disableClear,
  input wire logic [15:0] corePc,
  input wire logic [7:0] coreStatus,
  input wire logic [15:0] stackAddr,
  input wire logic [7:0] memRdata,
  output logic irqPending,
  output logic globalDisable,
  output logic stopMode,
  output logic [15:0] busAddr,
  output logic [7:0] busWdata,
  output logic busWrite,
  output logic busRead,
  output logic [15:0] newPc,
  output logic pcLoad
);
  viu_arb_if arbBus();

  logic [15:0] req_reg; // Request bits by slot
  logic [15:0] req_next;
  logic [15:0] ena_reg; // Enable bits by slot
  logic [5:0] edge_reg; // Falling-edge select per pin
  logic ser_reg; // Serial function selected on pins
  logic [3:0] last_reg; // Slot being or last served
  logic resetVec_reg; // Current fetch is the reset vector
  logic [7:0] vecLo_reg; // Captured low vector byte
  viu_state_t state_reg;
  logic [5:0] pinEdge; // Edge pulses from the pin detectors
  logic [15:0] hwSet; // Hardware set events by slot
  logic [15:0] swClr; // Software clear mask
  logic [15:0] accClr; // Acceptance clear mask
  logic accept; // Interrupt taken this cycle
  logic apbWr; // Write takes effect this edge
  logic mapped; // Address decodes to a register
  logic [31:0] rd_next;

  viu_edge_detect #(
    .N(VIU_EXT_PINS)
  ) uEdge (
    .clock(clock),
    .nrst(nrst),
    .pins({timerYEdgePin, timerXEdgePin, extIrqPinD, extIrqPinC, extIrqPinB, extIrqPinA}),
    .fallSel(edge_reg),
    .edgePulse(pinEdge)
  );

  viu_arbiter uArb (
    .bus(arbBus.arb)
  );

  // Hardware events placed in their priority slots
  always_comb
  begin
    hwSet = '0;
    hwSet[VIU_SLOT_PIN_A] = pinEdge[0]; // [R11]
    hwSet[VIU_SLOT_PIN_B] = pinEdge[1]; // [R11]
    hwSet[VIU_SLOT_PIN_C] = pinEdge[2]; // [R11]
    hwSet[VIU_SLOT_PIN_D] = pinEdge[3]; // [R11]
    hwSet[VIU_SLOT_CNT_X] = pinEdge[4]; // [R12]
    hwSet[VIU_SLOT_CNT_Y] = pinEdge[5]; // [R12]
    hwSet[VIU_SLOT_TX_UF] = timerXUnderflow; // [R13] [R20]
    hwSet[VIU_SLOT_TY_UF] = timerYUnderflow; // [R13] [R20]
    hwSet[VIU_SLOT_T1_UF] = timer1Underflow; // [R14] [R20]
    hwSet[VIU_SLOT_T2_UF] = timer2Underflow; // [R13] [R20]
    // Serial events count only while the pins carry the serial function
    hwSet[VIU_SLOT_RX] = serialRxDone & ser_reg; // [R15]
    hwSet[VIU_SLOT_TXS] = (serialTxShiftDone | serialTxBufEmpty) & ser_reg; // [R16]
    hwSet[VIU_SLOT_ADC] = adcDone; // [R17]
    hwSet[VIU_SLOT_BRK] = breakInstruction; // [R18]
  end

  // APB decode; slave answers in the first access cycle
  always_comb
  begin
    apbWr = psel & penable & pready & pwrite;
    mapped = (paddr == VIU_OFF_REQ) || (paddr == VIU_OFF_ENA) || (paddr == VIU_OFF_EDGE)
      || (paddr == VIU_OFF_CTRL) || (paddr == VIU_OFF_STAT);
    swClr = (apbWr && paddr == VIU_OFF_REQ) ? pwdata[15:0] : 16'h0000; // [R4]
    accClr = '0;
    accClr[arbBus.winner] = accept;
  end

  // Gated requests: break passes regardless of enables and disable flag
  always_comb
  begin
    arbBus.pending = req_reg & ena_reg & {VIU_SLOTS{~globalDisable}}; // [R2] [R1]
    arbBus.pending[VIU_SLOT_BRK] = req_reg[VIU_SLOT_BRK]; // [R5]
    accept = (state_reg == VIU_IDLE) & instrBoundary & arbBus.valid;
  end

  // Request bits: a hardware set wins over any clear in the same cycle
  always_comb
  begin
    req_next = ((req_reg & ~swClr & ~accClr) | hwSet) & VIU_SLOT_USED; // [R4] [R8] [R21]
  end

  // Request flag storage
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      req_reg <= VIU_REQ_RST;
    else
      req_reg <= req_next;
  end

  // Enable and edge select registers
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      ena_reg <= VIU_ENA_RST;
      edge_reg <= VIU_EDGE_RST;
      ser_reg <= VIU_SER_RST;
    end
    else if (apbWr)
    begin
      // Break has no enable; its bit stays clear
      if (paddr == VIU_OFF_ENA)
        ena_reg <= pwdata[15:0] & VIU_SLOT_USED & ~(16'h0001 << VIU_SLOT_BRK); // [R3]
      // An edge select change alone raises no request while the pin is steady
      if (paddr == VIU_OFF_EDGE)
        edge_reg <= pwdata[5:0]; // [R10]
      if (paddr == VIU_OFF_CTRL)
        ser_reg <= pwdata[VIU_CTRL_SER];
    end
  end

  // Global disable flag: acceptance sets it and wins over any clear
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      globalDisable <= VIU_IDIS_RST;
    else if (accept)
      globalDisable <= 1'b1; // [R8]
    else if (apbWr && paddr == VIU_OFF_CTRL)
      globalDisable <= pwdata[VIU_CTRL_IDIS];
    else if (disableClear)
      globalDisable <= 1'b0;
  end

  // Stop mode: timer 1 underflow releases it, even on the same cycle
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      stopMode <= 1'b0;
    else if (timer1Underflow)
      stopMode <= 1'b0; // [R14]
    else if (stopModeInstruction)
      stopMode <= 1'b1;
  end

  // Pending maskable or break request shown to the core
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      irqPending <= 1'b0;
    else
      irqPending <= arbBus.valid; // [R2]
  end

  // APB read data, ready and error, registered in the setup cycle
  always_comb
  begin
    rd_next = 32'h0000_0000;
    unique case (paddr)
      VIU_OFF_REQ: rd_next[15:0] = req_reg;
      VIU_OFF_ENA: rd_next[15:0] = ena_reg;
      VIU_OFF_EDGE: rd_next[5:0] = edge_reg;
      VIU_OFF_CTRL:
      begin
        rd_next[VIU_CTRL_IDIS] = globalDisable;
        rd_next[VIU_CTRL_SER] = ser_reg;
        rd_next[VIU_CTRL_STOP] = stopMode;
      end
      VIU_OFF_STAT:
      begin
        rd_next[3:0] = last_reg;
        rd_next[VIU_STAT_BUSY] = (state_reg != VIU_IDLE);
      end
      default: rd_next = 32'h0000_0000;
    endcase
  end

  // One wait-free access: ready rises for the first access cycle only
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel & ~penable & ~pready;
      pslverr <= psel & ~penable & ~pready & ~mapped;
      if (psel & ~penable & ~pready)
        prdata <= pwrite ? 32'h0000_0000 : rd_next;
    end
  end

  // Acceptance sequence: push PC high, PC low, status, then fetch vector
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      // Reset behaves as the top priority vector fetch
      state_reg <= VIU_VEC_L; // [R19]
      resetVec_reg <= 1'b1; // [R19]
      last_reg <= 4'h0;
      vecLo_reg <= 8'h00;
      busAddr <= 16'h0000;
      busWdata <= 8'h00;
      busWrite <= 1'b0;
      busRead <= 1'b0;
      newPc <= 16'h0000;
      pcLoad <= 1'b0;
    end
    else
    begin
      busWrite <= 1'b0;
      busRead <= 1'b0;
      pcLoad <= 1'b0;
      unique case (state_reg)
        VIU_IDLE:
        begin
          if (accept)
          begin
            // Winner latched on the same edge that clears its request bit
            last_reg <= arbBus.winner; // [R6]
            resetVec_reg <= 1'b0;
            busAddr <= stackAddr; // [R7]
            busWdata <= corePc[15:8]; // [R7]
            busWrite <= 1'b1;
            state_reg <= VIU_PUSH_H;
          end
        end
        VIU_PUSH_H:
        begin
          busAddr <= stackAddr - 16'h0001; // [R7]
          busWdata <= corePc[7:0]; // [R7]
          busWrite <= 1'b1;
          state_reg <= VIU_PUSH_L;
        end
        VIU_PUSH_L:
        begin
          // Status goes last, after the program counter
          busAddr <= stackAddr - 16'h0002; // [R7]
          busWdata <= coreStatus; // [R7]
          busWrite <= 1'b1;
          state_reg <= VIU_PUSH_P;
        end
        VIU_PUSH_P:
        begin
          state_reg <= VIU_VEC_L;
        end
        VIU_VEC_L:
        begin
          // Low byte at the even address
          busAddr <= resetVec_reg ? VIU_RESET_VEC_LO : viuVecLow(last_reg); // [R9] [R19]
          busRead <= 1'b1;
          state_reg <= VIU_VEC_H;
        end
        VIU_VEC_H:
        begin
          // High byte at the odd address; low byte still in flight
          busAddr <= busAddr | 16'h0001; // [R9]
          busRead <= 1'b1;
          state_reg <= VIU_LOAD;
        end
        VIU_LOAD:
        begin
          // Memory answers one cycle after the strobe: low byte now
          vecLo_reg <= memRdata; // [R9]
          state_reg <= VIU_DONE;
        end
        VIU_DONE:
        begin
          // High byte now; jump and go back to idle
          newPc <= {memRdata, vecLo_reg}; // [R9]
          pcLoad <= 1'b1;
          state_reg <= VIU_IDLE;
        end
      endcase
    end
  end
endmodule

//--- logic/viu_pkg.sv
// Constants, types and helper functions of the vectored priority interrupt unit.
// Assumes a 20 MHz clock and an APB slave with 32-bit data and byte addresses.
package viu_pkg;
  // Priority slots: slot i holds priority i+2 (priority 1 is reset)
  localparam int unsigned VIU_SLOTS = 16;
  localparam int unsigned VIU_SLOT_W = 4;
  // Reserved priorities 3 and 7
  localparam logic [15:0] VIU_SLOT_USED = 16'hFFDD;
  // Break instruction slot, priority 17, never masked
  localparam int unsigned VIU_SLOT_BRK = 15;
  // Source slots: pins a,b,c,d, timer underflows, serial, timer x and y edge, converter
  localparam int unsigned VIU_SLOT_PIN_A = 0;
  localparam int unsigned VIU_SLOT_PIN_B = 2;
  localparam int unsigned VIU_SLOT_PIN_C = 3;
  localparam int unsigned VIU_SLOT_PIN_D = 4;
  localparam int unsigned VIU_SLOT_TX_UF = 6;
  localparam int unsigned VIU_SLOT_TY_UF = 7;
  localparam int unsigned VIU_SLOT_T1_UF = 8;
  localparam int unsigned VIU_SLOT_T2_UF = 9;
  localparam int unsigned VIU_SLOT_RX = 10;
  localparam int unsigned VIU_SLOT_TXS = 11;
  localparam int unsigned VIU_SLOT_CNT_X = 12;
  localparam int unsigned VIU_SLOT_CNT_Y = 13;
  localparam int unsigned VIU_SLOT_ADC = 14;
  localparam int unsigned VIU_EXT_PINS = 6;
  // Vector table: reset low byte, two bytes per priority step
  localparam logic [15:0] VIU_RESET_VEC_LO = 16'hFFFC;
  // APB register byte offsets
  localparam logic [7:0] VIU_OFF_REQ = 8'h00;
  localparam logic [7:0] VIU_OFF_ENA = 8'h04;
  localparam logic [7:0] VIU_OFF_EDGE = 8'h08;
  localparam logic [7:0] VIU_OFF_CTRL = 8'h0C;
  localparam logic [7:0] VIU_OFF_STAT = 8'h10;
  // Control and status register fields
  localparam int unsigned VIU_CTRL_IDIS = 0;
  localparam int unsigned VIU_CTRL_SER = 1;
  localparam int unsigned VIU_CTRL_STOP = 2;
  localparam int unsigned VIU_STAT_BUSY = 8;
  // Reset values
  localparam logic [15:0] VIU_REQ_RST = 16'h0000;
  localparam logic [15:0] VIU_ENA_RST = 16'h0000;
  localparam logic [5:0] VIU_EDGE_RST = 6'h00;
  localparam logic VIU_IDIS_RST = 1'b1;
  localparam logic VIU_SER_RST = 1'b0;

  // Sequencer states, one-hot
  typedef enum logic [7:0] {
    VIU_IDLE = 8'h01,
    VIU_PUSH_H = 8'h02,
    VIU_PUSH_L = 8'h04,
    VIU_PUSH_P = 8'h08,
    VIU_VEC_L = 8'h10,
    VIU_VEC_H = 8'h20,
    VIU_LOAD = 8'h40,
    VIU_DONE = 8'h80
  } viu_state_t;

  // Low vector byte address of a slot; high byte is the next, odd address
  function automatic logic [15:0] viuVecLow(input logic [3:0] slot);
    // Five-bit step so the break slot (15 + 1) does not wrap to zero
    viuVecLow = VIU_RESET_VEC_LO - {10'h000, {1'b0, slot} + 5'h01, 1'b0};
  endfunction
endpackage

//--- logic/viu_arb_if.sv
// Carrier between the interrupt unit top and its priority arbiter.
// Assumes a single clock domain; pure combinational handshake.
interface viu_arb_if;
  logic [15:0] pending; // Gated requests per slot
  logic [3:0] winner; // Lowest pending slot
  logic valid; // Any slot pending
  modport arb (input pending, output winner, valid);
  modport user (output pending, input winner, valid);
endinterface

//--- logic/viu_edge_detect.sv
// Edge detectors for the external interrupt pins.
// Assumes pins are synchronous-ish inputs re-synchronised here; one clock.
module viu_edge_detect
  import viu_pkg::*;
#(
  parameter int unsigned N = VIU_EXT_PINS
)(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [N-1:0] pins,
  input wire logic [N-1:0] fallSel,
  output logic [N-1:0] edgePulse
);
  logic [N-1:0] sync1_reg; // First synchroniser stage, only read by sync2
  logic [N-1:0] sync2_reg; // Second stage
  logic [N-1:0] prev_reg; // Previous sampled level
  logic [N-1:0] edge_next;

  // Two-flop synchroniser, then one history stage
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end
    else
    begin
      sync1_reg <= pins; // [R22]
      sync2_reg <= sync1_reg; // [R22]
      prev_reg <= sync2_reg;
    end
  end

  // Selected edge: rising when fallSel low, falling when high
  always_comb
  begin
    edge_next = (fallSel & prev_reg & ~sync2_reg) | (~fallSel & ~prev_reg & sync2_reg); // [R22]
  end

  // Registered one-cycle pulse
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      edgePulse <= '0;
    else
      edgePulse <= edge_next;
  end
endmodule

//--- logic/viu_arbiter.sv
// Fixed priority arbiter: lowest slot number wins.
// Assumes pending already gated by enables and the disable flag.
module viu_arbiter
  import viu_pkg::*;
(
  viu_arb_if.arb bus
);
  // Lowest set bit search, reused for winner and valid
  function automatic logic [4:0] lowestSet(input logic [15:0] v);
    lowestSet = 5'h10;
    for (int i = VIU_SLOTS - 1; i >= 0; i--)
    begin
      if (v[i])
        lowestSet = 5'(i);
    end
  endfunction

  logic [4:0] pick;

  // Reserved slots are masked so they can never win
  always_comb
  begin
    pick = lowestSet(bus.pending & VIU_SLOT_USED); // [R6] [R21]
    bus.valid = ~pick[4];
    bus.winner = pick[3:0];
  end
endmodule

//--- testbench/viu_top_props.sv
// Checker for the interrupt unit top: stacking, vector fetch, stop mode, APB timing.
// Assumes it is bound to viu_top and sees only that module's ports.
module viu_top_props (
  input wire logic clock,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timer1Underflow,
  input wire logic stopModeInstruction,
  input wire logic globalDisable,
  input wire logic irqPending,
  input wire logic stopMode,
  input wire logic [15:0] busAddr,
  input wire logic busWrite,
  input wire logic busRead,
  input wire logic pcLoad
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  // Stacking: three writes in a row, then a quiet cycle
  sequence pushThree;
    busWrite ##1 busWrite ##1 busWrite ##1 !busWrite;
  endsequence
  // Vector fetch: even byte, odd byte, a gap, then the load
  sequence vecFetch;
    busRead && !busAddr[0] ##1 busRead && busAddr[0] ##2 pcLoad;
  endsequence
  push_three_a: assert property ($rose(busWrite) |-> pushThree)
    else $error("stacking is not three writes");
  push_down_a: assert property (busWrite && $past(busWrite) |-> busAddr == $past(busAddr) - 16'h0001)
    else $error("stack address did not step down");
  fetch_after_a: assert property ($rose(busWrite) |-> ##4 vecFetch)
    else $error("vector fetch not four cycles after stacking");
  vec_pair_a: assert property (busRead && !busAddr[0] |=> busAddr == ($past(busAddr) | 16'h0001))
    else $error("odd vector byte not next to even byte");
  disable_set_a: assert property (busWrite |-> globalDisable)
    else $error("disable flag clear during stacking");
  reserved_slot_a: assert property (busRead |-> busAddr[15:1] != 15'h7FFC && busAddr[15:1] != 15'h7FF8)
    else $error("reserved vector fetched");
  vec_range_a: assert property (busRead |-> busAddr >= 16'hFFDC)
    else $error("vector fetch below table");
  stop_release_a: assert property (timer1Underflow |=> !stopMode)
    else $error("timer 1 underflow did not end stop mode");
  stop_enter_a: assert property (stopModeInstruction && !timer1Underflow |=> stopMode)
    else $error("stop instruction did not set stop mode");
  irq_shown_a: assert property ($rose(busWrite) |-> irqPending)
    else $error("accepted request was not shown as pending");
  slverr_pair_a: assert property (pslverr |-> pready && $past(psel) && !$past(penable))
    else $error("slave error outside the access cycle");
  apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not a single access cycle");
endmodule

bind viu_top viu_top_props i_props (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .timer1Underflow(timer1Underflow),
  .stopModeInstruction(stopModeInstruction), .globalDisable(globalDisable),
  .irqPending(irqPending), .stopMode(stopMode),
  .busAddr(busAddr), .busWrite(busWrite), .busRead(busRead), .pcLoad(pcLoad));

//--- testbench/viu_core_model.sv
// Model of the processor core and its memory facing the interrupt unit.
// Assumes vector memory answers the cycle after a read strobe.
module viu_core_model (
  input wire logic clock,
  input wire logic nrst,
  input wire logic rtiEn,
  input wire logic [15:0] busAddr,
  input wire logic [7:0] busWdata,
  input wire logic busWrite,
  input wire logic busRead,
  input wire logic pcLoad,
  output logic instrBoundary,
  output logic disableClear,
  output logic [15:0] corePc,
  output logic [7:0] coreStatus,
  output logic [15:0] stackAddr,
  output logic [7:0] memRdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] pushIdx; // Next stack log slot
  logic [15:0] pushAddr [3]; // Logged stack addresses
  logic [7:0] pushData [3]; // Logged stack bytes
  logic [2:0] rtiDly; // Delay from load to return
  // Every cycle is a boundary, so acceptance is never held off
  assign instrBoundary = 1'h1;
  assign corePc = 16'h1234;
  assign coreStatus = 8'h20;
  assign stackAddr = 16'h01FF;
  // Vector memory; an idle bus inverts its last output each cycle, so the last read byte returns every second idle cycle
  always_ff @(posedge clock or negedge nrst)
    if (!nrst)
      memRdata <= 8'h00;
    else if (busRead)
      memRdata <= busAddr[7:0] ^ 8'h5A;
    else
      memRdata <= ~memRdata;
  // Stack log, restarted on each load
  always_ff @(posedge clock or negedge nrst)
    if (!nrst)
      pushIdx <= 2'h0;
    else if (pcLoad)
      pushIdx <= 2'h0;
    else if (busWrite)
    begin
      pushAddr[pushIdx] <= busAddr;
      pushData[pushIdx] <= busWdata;
      pushIdx <= pushIdx + 2'h1;
    end
  // Return from handler a few cycles after the load
  always_ff @(posedge clock or negedge nrst)
    if (!nrst)
    begin
      rtiDly <= 3'h0;
      disableClear <= 1'h0;
    end
    else
    begin
      rtiDly <= {rtiDly[1:0], pcLoad};
      disableClear <= rtiEn & rtiDly[2];
    end
endmodule

//--- testbench/viu_top_test.sv
// Self-checking bench for the interrupt unit: APB tasks and event bursts.
// Assumes the core model answers vector reads and returns from handlers.
module viu_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, rtiEn = 0, err;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, rd, prdata;
  logic pready, pslverr, extIrqPinA = 0, extIrqPinB = 0, extIrqPinC = 0, extIrqPinD = 0;
  logic timerXEdgePin = 0, timerYEdgePin = 0, timerXUnderflow = 0, timerYUnderflow = 0;
  logic timer1Underflow = 0, timer2Underflow = 0, serialRxDone = 0, serialTxShiftDone = 0;
  logic serialTxBufEmpty = 0, adcDone = 0, breakInstruction = 0, stopModeInstruction = 0;
  logic instrBoundary, disableClear, irqPending, globalDisable, stopMode, busWrite, busRead, pcLoad;
  logic [15:0] corePc, stackAddr, busAddr, newPc;
  logic [7:0] coreStatus, memRdata, busWdata;
  int failCount = 0;
  int checks = 0;
  // Free-running 20 MHz clock
  always #25 clock = ~clock;
  viu_top i_dut (.clock(clock), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extIrqPinA(extIrqPinA), .extIrqPinB(extIrqPinB), .extIrqPinC(extIrqPinC),
    .extIrqPinD(extIrqPinD), .timerXEdgePin(timerXEdgePin), .timerYEdgePin(timerYEdgePin),
    .timerXUnderflow(timerXUnderflow), .timerYUnderflow(timerYUnderflow),
    .timer1Underflow(timer1Underflow), .timer2Underflow(timer2Underflow),
    .serialRxDone(serialRxDone), .serialTxShiftDone(serialTxShiftDone),
    .serialTxBufEmpty(serialTxBufEmpty), .adcDone(adcDone), .breakInstruction(breakInstruction),
    .stopModeInstruction(stopModeInstruction), .instrBoundary(instrBoundary),
    .disableClear(disableClear), .corePc(corePc), .coreStatus(coreStatus),
    .stackAddr(stackAddr), .memRdata(memRdata), .irqPending(irqPending),
    .globalDisable(globalDisable), .stopMode(stopMode), .busAddr(busAddr), .busWdata(busWdata),
    .busWrite(busWrite), .busRead(busRead), .newPc(newPc), .pcLoad(pcLoad));
  viu_core_model i_core (.clock(clock), .nrst(nrst), .rtiEn(rtiEn), .busAddr(busAddr),
    .busWdata(busWdata), .busWrite(busWrite), .busRead(busRead), .pcLoad(pcLoad),
    .instrBoundary(instrBoundary), .disableClear(disableClear), .corePc(corePc),
    .coreStatus(coreStatus), .stackAddr(stackAddr), .memRdata(memRdata));
  // Expected memory byte, mirrors the model's contents
  function automatic logic [7:0] mem(input logic [15:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction
  // Compare and count
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      failCount++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    @(posedge clock);
    // No wait limit here: only the watchdog ends a hung transfer
    while (pready !== 1'h1)
      @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk("register", e, rd);
  endtask
  // Fire sources by slot mask; pins toggle, bit 1 stands for buffer empty
  task automatic fire(input logic [15:0] m);
    @(posedge clock);
    extIrqPinA <= extIrqPinA ^ m[0];
    extIrqPinB <= extIrqPinB ^ m[2];
    extIrqPinC <= extIrqPinC ^ m[3];
    extIrqPinD <= extIrqPinD ^ m[4];
    timerXEdgePin <= timerXEdgePin ^ m[12];
    timerYEdgePin <= timerYEdgePin ^ m[13];
    {serialTxBufEmpty, timerXUnderflow, timerYUnderflow, timer1Underflow, timer2Underflow} <=
      {m[1], m[6], m[7], m[8], m[9]};
    {serialRxDone, serialTxShiftDone, adcDone, breakInstruction} <= {m[10], m[11], m[14], m[15]};
    @(posedge clock);
    {serialTxBufEmpty, timerXUnderflow, timerYUnderflow, timer1Underflow} <= 4'h0;
    {timer2Underflow, serialRxDone, serialTxShiftDone, adcDone, breakInstruction} <= 5'h00;
    repeat (5) @(posedge clock);
  endtask
  // Wait for the program counter load, bounded
  task automatic waitPc(input logic [15:0] e);
    int n = 0;
    do
    begin
      @(posedge clock);
      #1;
      n++;
    end
    while (pcLoad !== 1'h1 && n < 60);
    chk("pcLoad", 32'h1, 32'(pcLoad));
    chk("newPc", 32'(e), 32'(newPc));
  endtask
  // Service of one slot: vector, disable flag, stacked bytes
  task automatic vec(input int s);
    logic [15:0] lo;
    lo = 16'hFFFC - 16'(2 * (s + 1));
    waitPc({mem(lo | 16'h0001), mem(lo)});
    chk("globalDisable", 32'h1, 32'(globalDisable));
    for (int k = 0; k < 3; k++)
    begin
      chk("pushAddr", 32'(16'h01FF - 16'(k)), 32'(i_core.pushAddr[k]));
      chk("pushData", 32'(k == 0 ? 8'h12 : k == 1 ? 8'h34 : 8'h20), 32'(i_core.pushData[k]));
    end
  endtask
  // Verdict and end of run
  task automatic results;
    $display("checks %0d errors %0d", checks, failCount);
    if (failCount == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial
  begin
    repeat (20000) @(posedge clock);
    failCount++;
    results;
  end
  // Main sequence
  initial
  begin
    repeat (10) @(posedge clock);
    nrst <= 1'h1;
    waitPc({mem(16'hFFFD), mem(16'hFFFC)});
    rdchk(8'h00, 32'h0);
    rdchk(8'h04, 32'h0);
    rdchk(8'h08, 32'h0);
    rdchk(8'h0C, 32'h1);
    apb(1'h0, 8'h14, 32'h0);
    chk("pslverr", 32'h1, 32'(err));
    apb(1'h1, 8'h04, 32'hFFFF);
    rdchk(8'h04, 32'h7FDD);
    apb(1'h1, 8'h0C, 32'h3);
    // Break left out: it is unmaskable and would be served at once
    fire(16'h7FDD);
    rdchk(8'h00, 32'h7FDD);
    rtiEn <= 1'h1;
    apb(1'h1, 8'h0C, 32'h2);
    for (int s = 0; s < 15; s++)
      if (s != 1 && s != 5)
        vec(s);
    // Let the last return clear the flag before the break arrives
    repeat (8) @(posedge clock);
    fire(16'h8000);
    vec(15);
    repeat (8) @(posedge clock);
    rtiEn <= 1'h0;
    rdchk(8'h00, 32'h0);
    apb(1'h1, 8'h0C, 32'h3);
    fire(16'hC000);
    vec(15);
    rdchk(8'h00, 32'h4000);
    chk("irqPending", 32'h0, 32'(irqPending));
    apb(1'h1, 8'h00, 32'hBFFF);
    rdchk(8'h00, 32'h4000);
    apb(1'h1, 8'h00, 32'h4000);
    rdchk(8'h00, 32'h0);
    apb(1'h1, 8'h0C, 32'h1);
    fire(16'h0402);
    rdchk(8'h00, 32'h0);
    apb(1'h1, 8'h0C, 32'h3);
    fire(16'h0002);
    rdchk(8'h00, 32'h0800);
    apb(1'h1, 8'h04, 32'h0);
    apb(1'h1, 8'h08, 32'h1);
    apb(1'h1, 8'h00, 32'hFFFF);
    fire(16'h0001);
    rdchk(8'h00, 32'h1);
    @(posedge clock);
    stopModeInstruction <= 1'h1;
    @(posedge clock);
    stopModeInstruction <= 1'h0;
    @(posedge clock);
    chk("stopMode", 32'h1, 32'(stopMode));
    fire(16'h0100);
    chk("stopMode", 32'h0, 32'(stopMode));
    results;
  end
endmodule
